// ==== verilog/spi_pkg.sv ====
// constants, field layout and carrier types of the serial status and select block
// How it works
// [RULE1] select-manage bit replaces pin with soft level
// [RULE2] soft level 0 selects, 1 deselects
// [RULE3] master keeps internal select high throughout
// [RULE4] phase-1 slave: select low whole message
// [RULE5] phase-0 slave: raise select between bytes
// [RULE6] wait mode leaves the unit running
// [RULE7] halt freezes unit and registers; a slave selected at halt entry keeps shifting
// [RULE8] slave done wakes halt; fault never does
// [RULE9] after halt wake run one spare transfer
// [RULE10] three events share one masked enable
// [RULE11] done flag: set, cleared status-then-data
// [RULE12] data writes blocked until status read
// [RULE13] write during transfer sets collision flag
// [RULE14] done while flag set raises overrun
// [RULE15] several unread transfers also raise overrun
// [RULE16] master select low sets fault flag
// [RULE17] output-disable releases the data output
// [RULE18] status register resets zero, bit3 reserved
// [RULE19] master data write starts a byte
// [RULE20] received byte copied to readable buffer
// [RULE21] data write loads shift register directly
// [RULE22] separate control register holds mode bits
package spi_pkg;
    localparam logic [1:0] ADDR_CTRL   = 2'h0;
    localparam logic [1:0] ADDR_CSR    = 2'h1;
    localparam logic [1:0] ADDR_DATA   = 2'h2;
    localparam int         CSR_DONE    = 7;
    localparam int         CSR_WRITE_COLLISION_FLAG    = 6;
    localparam int         CSR_OVR     = 5;
    localparam int         CSR_FAULT   = 4;
    localparam int         CSR_ODIS    = 2;
    localparam int         CSR_SSM     = 1;
    localparam int         CSR_SSI     = 0;
    localparam int         CTRL_IE     = 7;
    localparam int         CTRL_EN     = 6;
    localparam int         CTRL_MSTR   = 4;
    localparam int         CTRL_CPOL   = 3;
    localparam int         CTRL_CPHA   = 2;
    localparam logic [7:0] CSR_RESET   = 8'h00;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [2:0] BIT_LAST    = 3'h7;
    localparam logic [3:0] EDGE_LAST   = 4'hf;
    localparam int         SCK_HALF_DEF = 4;

    // one register access from software
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // the three serial lines, used for levels, drives and enables
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
    } line_s;
endpackage

// ==== verilog/spi_status_slave_select.sv ====
// serial unit with status flags, select management, receive buffer and halt wake
`timescale 1ns/1ps
module spi_status_slave_select
    import spi_pkg::*;
#(
    parameter int SCK_HALF = SCK_HALF_DEF
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire reg_req_s   req,
    output logic [7:0]      rdata,
    input  wire logic       cpu_irq_mask,
    input  wire logic       halt_mode,
    output logic            irq,
    output logic            halt_wake,
    input  wire line_s      pin_in,
    input  wire logic       ss_pin_n,
    output line_s           pin_out,
    output line_s           pin_oe
);

    localparam int DW = (SCK_HALF < 2) ? 1 : $clog2(SCK_HALF);
    localparam logic [DW-1:0] HALF_LAST = DW'(SCK_HALF - 1);

    if (SCK_HALF < 2) begin : g_bad_half
        $error("SCK_HALF must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic          unit_enable;
    logic          master_mode;
    logic          clk_pol;
    logic          clk_pha;
    logic          shared_irq_enable;
    logic          xfer_done_flag;
    logic          write_collision_flag;
    logic          overrun_flag;
    logic          master_fault_flag;
    logic          output_disable;
    logic          select_soft_manage;
    logic          soft_select_level;
    logic          csr_seen;
    logic          fault_seen;
    line_s         sync1;
    line_s         sync2;
    logic          ss1_n;
    logic          ss2_n;
    logic          sck_prev;
    logic          m_busy;
    logic          m_sck;
    logic [DW-1:0] div_cnt;
    logic [3:0]    edge_cnt;
    logic [7:0]    shreg;
    logic [7:0]    rx_buf;
    logic [2:0]    bit_cnt;
    logic          dout;
    logic          halt_prev;
    logic          halt_slave_ok;
    logic [7:0]    next_rdata;

    logic ss_int_n;
    logic run;
    logic slave_act;
    logic s_lead;
    logic s_trail;
    logic half_tick;
    logic lead;
    logic trail;
    logic sample_ev;
    logic shift_ev;
    logic in_bit;
    logic done_ev;
    logic bus_ok;
    logic wr_dr;
    logic rd_dr;
    logic rd_csr;
    logic wr_csr;
    logic wr_ctrl;
    logic busy_tx;
    logic dr_blocked;
    logic load_ok;
    logic collide;
    logic m_start;
    logic seq_clear;
    logic fault_ev;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers, two stages before any use

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sync1 <= '0;
            sync2 <= '0;
            ss1_n <= 1'b1;
            ss2_n <= 1'b1;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1;
            ss1_n <= ss_pin_n;
            ss2_n <= ss1_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // internal select, edges and bus decode

    // pin ignored under software management
    assign ss_int_n  = select_soft_manage ? soft_select_level : ss2_n; // [RULE1] [RULE2]
    // in halt only a slave selected at entry keeps shifting
    assign run       = !halt_mode || halt_slave_ok;                    // [RULE7]
    assign slave_act = unit_enable && !master_mode && !ss_int_n;
    assign s_lead    = slave_act && (sync2.sck != sck_prev) && (sync2.sck != clk_pol);
    assign s_trail   = slave_act && (sync2.sck != sck_prev) && (sync2.sck == clk_pol);
    assign half_tick = m_busy && (div_cnt == HALF_LAST);
    assign lead      = master_mode ? (half_tick && m_sck == clk_pol) : s_lead;
    assign trail     = master_mode ? (half_tick && m_sck != clk_pol) : s_trail;
    assign sample_ev = clk_pha ? trail : lead;
    assign shift_ev  = clk_pha ? lead : trail;
    assign in_bit    = master_mode ? sync2.miso : sync2.mosi;
    assign done_ev   = run && sample_ev && (bit_cnt == BIT_LAST);

    // the cpu is stopped in halt, so no access is taken then
    assign bus_ok  = !halt_mode;
    assign wr_dr   = bus_ok && req.wr && (req.addr == ADDR_DATA);
    assign rd_dr   = bus_ok && req.rd && (req.addr == ADDR_DATA);
    assign rd_csr  = bus_ok && req.rd && (req.addr == ADDR_CSR);
    assign wr_csr  = bus_ok && req.wr && (req.addr == ADDR_CSR);
    assign wr_ctrl = bus_ok && req.wr && (req.addr == ADDR_CTRL);

    // phase 0 slave counts as busy for the whole select-low time
    assign busy_tx    = master_mode ? m_busy
                      : (slave_act && (!clk_pha || bit_cnt != 3'h0)); // [RULE5] [RULE4]
    assign dr_blocked = xfer_done_flag && !csr_seen;                  // [RULE12]
    assign load_ok    = wr_dr && !dr_blocked && !busy_tx && unit_enable;
    assign collide    = wr_dr && !dr_blocked && busy_tx;              // [RULE13]
    assign m_start    = load_ok && master_mode;                       // [RULE19]
    assign seq_clear  = (rd_dr || wr_dr) && csr_seen;                 // [RULE11]
    // master expects the select high; low is a fault
    assign fault_ev   = unit_enable && master_mode && !ss_int_n;      // [RULE3] [RULE16]

    ////////////////////////////////////////////////////////////////////////
    // control register, separate from status

    always_ff @(posedge clk) begin
        if (!rstn) begin
            shared_irq_enable <= CTRL_RESET[CTRL_IE];
            unit_enable       <= CTRL_RESET[CTRL_EN];
            master_mode       <= CTRL_RESET[CTRL_MSTR];
            clk_pol           <= CTRL_RESET[CTRL_CPOL];
            clk_pha           <= CTRL_RESET[CTRL_CPHA];
        end else if (wr_ctrl) begin                                   // [RULE22]
            shared_irq_enable <= req.wdata[CTRL_IE];
            unit_enable       <= req.wdata[CTRL_EN];
            master_mode       <= req.wdata[CTRL_MSTR];
            clk_pol           <= req.wdata[CTRL_CPOL];
            clk_pha           <= req.wdata[CTRL_CPHA];
        end
    end

    // software bits of the status register, reserved bit not stored
    always_ff @(posedge clk) begin
        if (!rstn) begin
            output_disable     <= CSR_RESET[CSR_ODIS];                // [RULE18]
            select_soft_manage <= CSR_RESET[CSR_SSM];
            soft_select_level  <= CSR_RESET[CSR_SSI];
        end else if (wr_csr) begin
            output_disable     <= req.wdata[CSR_ODIS];
            select_soft_manage <= req.wdata[CSR_SSM];
            soft_select_level  <= req.wdata[CSR_SSI];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clearing sequence trackers

    always_ff @(posedge clk) begin
        if (!rstn) begin
            csr_seen   <= 1'b0;
            fault_seen <= 1'b0;
        end else begin
            if (rd_dr || wr_dr) begin
                csr_seen <= 1'b0;
            end
            if (rd_csr) begin
                csr_seen <= 1'b1;
            end
            if (wr_ctrl) begin
                fault_seen <= 1'b0;
            end else if (rd_csr && master_fault_flag) begin
                fault_seen <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // hardware flags, set wins over clear

    always_ff @(posedge clk) begin
        if (!rstn) begin
            xfer_done_flag       <= CSR_RESET[CSR_DONE];              // [RULE18]
            write_collision_flag <= CSR_RESET[CSR_WRITE_COLLISION_FLAG];
            overrun_flag         <= CSR_RESET[CSR_OVR];
            master_fault_flag    <= CSR_RESET[CSR_FAULT];
        end else begin
            if (seq_clear) begin
                xfer_done_flag       <= 1'b0;                         // [RULE11]
                write_collision_flag <= 1'b0;
            end
            if (done_ev) begin
                xfer_done_flag <= 1'b1;                               // [RULE11]
            end
            if (collide) begin
                write_collision_flag <= 1'b1;                         // [RULE13] [RULE5]
            end
            if (rd_csr) begin
                overrun_flag <= 1'b0;                                 // [RULE14]
            end
            if (done_ev && xfer_done_flag) begin
                overrun_flag <= 1'b1;                                 // [RULE14] [RULE15]
            end
            if (wr_ctrl && fault_seen) begin
                master_fault_flag <= 1'b0;                            // [RULE16]
            end
            if (fault_ev && !halt_mode) begin
                master_fault_flag <= 1'b1;                            // [RULE16]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // master clock generator

    always_ff @(posedge clk) begin
        if (!rstn) begin
            m_busy   <= 1'b0;
            m_sck    <= 1'b0;
            div_cnt  <= '0;
            edge_cnt <= 4'h0;
            sck_prev <= 1'b0;
        end else if (!halt_mode) begin                                // [RULE7]
            sck_prev <= sync2.sck;
            if (!unit_enable || !master_mode) begin
                m_busy <= 1'b0;
                m_sck  <= clk_pol;
            end else if (m_start) begin                               // [RULE19]
                m_busy   <= 1'b1;
                div_cnt  <= '0;
                edge_cnt <= 4'h0;
            end else if (m_busy) begin
                div_cnt <= half_tick ? '0 : div_cnt + 1'b1;
                if (half_tick) begin
                    m_sck    <= !m_sck;
                    edge_cnt <= edge_cnt + 4'h1;
                    if (edge_cnt == EDGE_LAST) begin
                        m_busy <= 1'b0;
                    end
                end
            end else begin
                m_sck <= clk_pol;
            end
        end else begin
            sck_prev <= sync2.sck;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shift register, receive buffer and output bit

    always_ff @(posedge clk) begin
        if (!rstn) begin
            shreg   <= 8'h00;
            rx_buf  <= 8'h00;
            bit_cnt <= 3'h0;
            dout    <= 1'b0;
        end else if (run) begin                                       // [RULE7] [RULE6]
            if (load_ok) begin
                shreg   <= req.wdata;                                 // [RULE21]
                dout    <= req.wdata[7];
                bit_cnt <= 3'h0;
            end else if (!master_mode && ss_int_n) begin
                bit_cnt <= 3'h0;                                      // [RULE5]
                dout    <= shreg[7];
            end else begin
                if (sample_ev) begin
                    shreg   <= {shreg[6:0], in_bit};
                    bit_cnt <= bit_cnt + 3'h1;
                end
                if (done_ev) begin
                    rx_buf <= {shreg[6:0], in_bit};                   // [RULE20]
                end
                if (shift_ev) begin
                    dout <= shreg[7];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // halt entry capture and wake request

    always_ff @(posedge clk) begin
        if (!rstn) begin
            halt_prev     <= 1'b0;
            halt_slave_ok <= 1'b0;
            halt_wake     <= 1'b0;
        end else begin
            halt_prev <= halt_mode;
            if (!halt_mode) begin
                halt_slave_ok <= 1'b0;
            end else if (!halt_prev) begin
                halt_slave_ok <= slave_act;                           // [RULE8]
            end
            // only a completed transfer wakes, never a fault
            halt_wake <= halt_mode && halt_slave_ok && shared_irq_enable
                         && xfer_done_flag;                           // [RULE8]
        end
    end

    // one shared request, not gated by wait
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= shared_irq_enable && !cpu_irq_mask
                   && (xfer_done_flag || overrun_flag || master_fault_flag); // [RULE10] [RULE6]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else begin
            pin_out.sck  <= m_sck;
            pin_out.mosi <= dout;
            pin_out.miso <= dout;
            pin_oe.sck   <= unit_enable && master_mode;
            pin_oe.mosi  <= unit_enable && master_mode && !output_disable;       // [RULE17]
            pin_oe.miso  <= slave_act && !output_disable;                        // [RULE17]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read port, data one cycle after the strobe

    always_comb begin
        next_rdata = 8'h00;
        unique case (req.addr)
            ADDR_CTRL: next_rdata = {shared_irq_enable, unit_enable, 1'b0, master_mode,
                                     clk_pol, clk_pha, 2'b00};
            ADDR_CSR:  next_rdata = {xfer_done_flag, write_collision_flag, overrun_flag,
                                     master_fault_flag, 1'b0, output_disable,
                                     select_soft_manage, soft_select_level};
            ADDR_DATA: next_rdata = rx_buf;                           // [RULE20]
            default:   next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else begin
            rdata <= req.rd ? next_rdata : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_soft_deselect;
        select_soft_manage && soft_select_level && !ss2_n |=> !pin_oe.miso;
    endproperty
    a_soft_deselect: assert property (p_soft_deselect) // [RULE1]
        else $error("soft deselect did not release slave output");

    property p_soft_select;
        select_soft_manage && !soft_select_level && unit_enable && !master_mode
            && !output_disable |=> pin_oe.miso;
    endproperty
    a_soft_select: assert property (p_soft_select) // [RULE2]
        else $error("soft select did not enable slave output");

    property p_done_set;
        done_ev |=> xfer_done_flag;
    endproperty
    a_done_set: assert property (p_done_set) // [RULE11]
        else $error("done flag not set after transfer");

    sequence s_status_read;
        rd_csr;
    endsequence
    sequence s_data_read;
        rd_dr && !done_ev;
    endsequence
    // an idle cycle between the two accesses keeps the status read in force
    property p_done_clear;
        s_status_read ##1 (!rd_dr && !wr_dr) ##1 s_data_read |=> !xfer_done_flag;
    endproperty
    a_done_clear: assert property (p_done_clear) // [RULE11]
        else $error("done flag survived clearing sequence");

    property p_write_blocked;
        wr_dr && xfer_done_flag && !csr_seen && !sample_ev |=> $stable(shreg);
    endproperty
    a_write_blocked: assert property (p_write_blocked) // [RULE12]
        else $error("data write taken while done flag unread");

    property p_collision;
        wr_dr && !dr_blocked && busy_tx
            |=> write_collision_flag && ($stable(shreg) || $past(sample_ev));
    endproperty
    a_collision: assert property (p_collision) // [RULE13]
        else $error("collision not flagged");

    property p_overrun;
        done_ev && xfer_done_flag |=> overrun_flag ##1 1'b1;
    endproperty
    a_overrun: assert property (p_overrun) // [RULE14]
        else $error("overrun not flagged");

    property p_overrun_clear;
        rd_csr && !done_ev |=> !overrun_flag;
    endproperty
    a_overrun_clear: assert property (p_overrun_clear) // [RULE14]
        else $error("overrun not cleared by status read");

    sequence s_fault_read;
        rd_csr && master_fault_flag;
    endsequence
    sequence s_ctrl_write;
        wr_ctrl && !fault_ev;
    endsequence
    property p_fault_clear;
        s_fault_read ##1 !wr_ctrl ##1 s_ctrl_write |=> !master_fault_flag;
    endproperty
    a_fault_clear: assert property (p_fault_clear) // [RULE16]
        else $error("fault flag survived clearing sequence");

    property p_output_disable;
        output_disable |=> !pin_oe.mosi && !pin_oe.miso;
    endproperty
    a_output_disable: assert property (p_output_disable) // [RULE17]
        else $error("data output driven while disabled");

    property p_irq_masked;
        cpu_irq_mask || !shared_irq_enable |=> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) // [RULE10]
        else $error("interrupt raised while masked");

    property p_no_fault_wake;
        halt_mode && !xfer_done_flag |=> !halt_wake;
    endproperty
    a_no_fault_wake: assert property (p_no_fault_wake) // [RULE8]
        else $error("halt wake without completed transfer");

    property p_halt_frozen;
        halt_mode && !halt_slave_ok |=> $stable(shreg) && $stable(rx_buf);
    endproperty
    a_halt_frozen: assert property (p_halt_frozen) // [RULE7]
        else $error("registers changed in halt");

    property p_master_start;
        m_start |=> m_busy ##[1:600] !m_busy;
    endproperty
    a_master_start: assert property (p_master_start) // [RULE19]
        else $error("master byte did not start or end");

    property p_direct_load;
        load_ok |=> shreg == $past(req.wdata);
    endproperty
    a_direct_load: assert property (p_direct_load) // [RULE21]
        else $error("data write not in shift register");

    property p_read_buffer;
        rd_dr |=> rdata == $past(rx_buf);
    endproperty
    a_read_buffer: assert property (p_read_buffer) // [RULE20]
        else $error("data read did not return buffer");

endmodule // spi_status_slave_select

// ==== sim/spi_far_end.sv ====
// far-end serial device: byte master on request, answering slave otherwise
`timescale 1ns/1ps
module spi_far_end (
    input  wire logic m_sck,
    input  wire logic m_mosi,
    output logic      sck,
    output logic      mosi,
    output logic      miso,
    output logic      ss_n
);
    logic [7:0] reply;
    logic [7:0] got;
    logic [2:0] cnt;
    initial begin
        {sck, mosi, ss_n, reply, got, cnt} = {3'b001, 19'h0};
    end
    // slave side: next bit out on each trailing edge, msb first
    assign miso = reply[3'h7 - cnt];
    always @(negedge m_sck) cnt <= cnt + 3'h1;
    // capture what the block sends on each leading edge
    always @(posedge m_sck) got <= {got[6:0], m_mosi};
    // load the reply byte while the link is idle
    task automatic prep(input logic [7:0] r);
        reply = r;
        cnt = 3'h0;
    endtask
    // one byte as master; clock rests low between frames
    task automatic send(input logic [7:0] b);
        #3;
        for (int i = 7; i >= 0; i--) begin
            mosi = b[i];
            #80 sck = 1'b1;
            #80 sck = 1'b0;
        end
        mosi = ~b[0]; // released line shows no stale level
    endtask
    // select stays low across a whole message when held
    task automatic set_ss(input logic n);
        ss_n = n;
    endtask
endmodule // spi_far_end

// ==== sim/testbench.sv ====
// self-checking bench for the serial status and select block
`timescale 1ns/1ps
module testbench;
    import spi_pkg::*;
    logic        clk, rstn, cpu_irq_mask, halt_mode, irq, halt_wake, mosi_seen;
    reg_req_s    req;
    logic [7:0]  rdata, v, x, y, heard;
    logic [2:0]  lo;
    line_s       pin_out, pin_oe, lv;
    logic        f_sck, f_mosi, f_miso, f_ss_n;
    logic [31:0] seed;
    int          n_errors, n_checks;
    // wire levels: an enabled driver wins, else the far end
    assign lv.sck = pin_oe.sck ? pin_out.sck : f_sck;
    assign lv.mosi = pin_oe.mosi ? pin_out.mosi : f_mosi;
    assign lv.miso = pin_oe.miso ? pin_out.miso : f_miso;
    spi_status_slave_select i_spi_status_slave_select (.clk(clk), .rstn(rstn), .req(req),
        .rdata(rdata), .cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode), .irq(irq),
        .halt_wake(halt_wake), .pin_in(lv), .ss_pin_n(f_ss_n), .pin_out(pin_out),
        .pin_oe(pin_oe));
    spi_far_end i_spi_far_end (.m_sck(lv.sck), .m_mosi(lv.mosi), .sck(f_sck),
        .mosi(f_mosi), .miso(f_miso), .ss_n(f_ss_n));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // remember whether the data output was ever enabled
    always @(posedge clk) if (pin_oe.mosi === 1'b1) mosi_seen <= 1'b1;
    // what the far end hears on the slave output line
    always @(posedge lv.sck) heard <= {heard[6:0], lv.miso};
    function logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function logic [7:0] csr_exp(input logic [3:0] f, input logic [2:0] l);
        return {f, 1'b0, l};
    endfunction
    task end_sim;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task wr(input logic [1:0] a, input logic [7:0] d);
        req <= {1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task rdc(input logic [1:0] a, input logic [7:0] e);
        req <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        req <= '0;
        #1 v = rdata;
        @(posedge clk);
        chk(v, e);
    endtask
    task waitw;
        int k;
        for (k = 0; k < 3000 && irq !== 1'b1 && halt_wake !== 1'b1; k++) @(posedge clk);
        if (k == 3000) begin
            n_errors++;
            $display("BAD %0t no completion seen", $time);
            end_sim;
        end
    endtask
    task xfer(input logic [7:0] xv, input logic [7:0] yv);
        i_spi_far_end.prep(yv);
        wr(ADDR_DATA, xv);
        waitw;
    endtask
    task tend(input string s);
        $display("test %s ended, %0d checks", s, n_checks);
    endtask
    initial begin
        req = '0;
        rstn = 1'b0;
        cpu_irq_mask = 1'b0;
        halt_mode = 1'b0;
        mosi_seen = 1'b0;
        n_errors = 0;
        n_checks = 0;
        seed = 32'h947c;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 4; a++) rdc(a[1:0], 8'h00);
        tend("reset");
        // master bytes at random, the last with the data output disabled
        wr(ADDR_CTRL, 8'hd0);
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            x = seed[7:0];
            y = seed[15:8];
            lo = (i == 2) ? 3'h7 : 3'h3;
            wr(ADDR_CSR, {5'h00, lo});
            @(posedge clk); // let the output enable settle before clearing
            mosi_seen <= 1'b0;
            xfer(x, y);
            chk({7'h0, mosi_seen}, (i == 2) ? 8'h00 : 8'h01);
            if (i < 2) chk(i_spi_far_end.got, x);
            rdc(ADDR_CSR, csr_exp(4'h8, lo));
            rdc(ADDR_DATA, y);
            rdc(ADDR_CSR, csr_exp(4'h0, lo));
        end
        tend("master");
        // blocked write while done, then a write during a byte
        wr(ADDR_CSR, 8'h03);
        xfer(8'h5a, 8'hc3);
        wr(ADDR_DATA, 8'ha5);
        repeat (300) @(posedge clk);
        rdc(ADDR_CSR, csr_exp(4'h8, 3'h3));
        chk(i_spi_far_end.got, 8'h5a);
        wr(ADDR_DATA, 8'h11);
        wr(ADDR_DATA, 8'h22);
        waitw;
        rdc(ADDR_CSR, csr_exp(4'hc, 3'h3));
        chk(i_spi_far_end.got, 8'h11);
        rdc(ADDR_DATA, 8'hc3);
        rdc(ADDR_CSR, csr_exp(4'h0, 3'h3));
        tend("collision");
        // pin select low in master mode, first masked
        wr(ADDR_CSR, 8'h00);
        cpu_irq_mask <= 1'b1;
        i_spi_far_end.set_ss(1'b0);
        repeat (16) @(posedge clk);
        chk({7'h0, irq}, 8'h00);
        cpu_irq_mask <= 1'b0;
        waitw;
        i_spi_far_end.set_ss(1'b1);
        repeat (8) @(posedge clk);
        rdc(ADDR_CSR, csr_exp(4'h1, 3'h0));
        wr(ADDR_CTRL, 8'hd0);
        rdc(ADDR_CSR, 8'h00);
        tend("fault");
        // slave under soft select, pin high; then two unread bytes
        wr(ADDR_CTRL, 8'hc0);
        wr(ADDR_CSR, 8'h02);
        i_spi_far_end.send(8'h3c);
        waitw;
        rdc(ADDR_CSR, csr_exp(4'h8, 3'h2));
        rdc(ADDR_DATA, 8'h3c);
        i_spi_far_end.send(8'h01);
        i_spi_far_end.send(8'h02);
        repeat (8) @(posedge clk);
        rdc(ADDR_CSR, csr_exp(4'ha, 3'h2));
        rdc(ADDR_CSR, csr_exp(4'h8, 3'h2));
        rdc(ADDR_DATA, 8'h02);
        tend("overrun");
        // pin low ignored under soft deselect, then it selects the slave into halt
        wr(ADDR_CSR, 8'h03);
        i_spi_far_end.set_ss(1'b0);
        repeat (8) @(posedge clk);
        chk({7'h0, pin_oe.miso}, 8'h00);
        wr(ADDR_CSR, 8'h00);
        repeat (8) @(posedge clk);
        cpu_irq_mask <= 1'b1;
        halt_mode <= 1'b1;
        wr(ADDR_CTRL, 8'h00);
        i_spi_far_end.send(8'h77);
        waitw;
        chk({7'h0, halt_wake}, 8'h01);
        halt_mode <= 1'b0;
        rdc(ADDR_CTRL, 8'hc0);
        rdc(ADDR_CSR, csr_exp(4'h8, 3'h0));
        rdc(ADDR_DATA, 8'h77);
        // spare byte after the wake brings the slave back to normal
        cpu_irq_mask <= 1'b0;
        i_spi_far_end.send(8'h5c);
        waitw;
        chk(heard, 8'h77);
        rdc(ADDR_DATA, 8'h5c);
        tend("halt");
        end_sim;
    end
endmodule // testbench
